// ### pkg/aux_cmd_pkg.sv
// package of command codes, field positions, reset values and timing counts
// for the auxiliary command decoder; assumes a 25 MHz core clock.
package aux_cmd_pkg;
   // command codes, bit 7 excluded
   localparam logic [6:0] CMD_SWRST = 7'h00;
   localparam logic [6:0] CMD_FEOI = 7'h08;
   localparam logic [6:0] CMD_LON = 7'h09;
   localparam logic [6:0] CMD_TON = 7'h0A;
   localparam logic [6:0] CMD_DAI = 7'h13;
   localparam logic [6:0] CMD_PTS = 7'h14;
   localparam logic [6:0] CMD_STDL = 7'h15;
   localparam logic [6:0] CMD_VSTDL = 7'h17;
   localparam logic [6:0] CMD_ALT_SERVICE_REQUEST = 7'h18;
   localparam logic [6:0] CMD_SW = 7'h19;
   localparam logic [6:0] CMD_REQ = 7'h1A;
   localparam logic [6:0] CMD_CHRST = 7'h1C;
   localparam int SET_BIT = 7;
   // register offsets on the local port
   localparam logic [3:0] OFS_AUX = 4'h0;
   localparam logic [3:0] OFS_SERIAL_POLL_MODE_REGISTER = 4'h1;
   localparam logic [3:0] OFS_CFG = 4'h2;
   localparam logic [3:0] OFS_ACC_A = 4'h3;
   localparam logic [3:0] OFS_ACC_B = 4'h4;
   localparam logic [3:0] OFS_ACC_E = 4'h5;
   localparam logic [3:0] OFS_ACC_F = 4'h6;
   localparam logic [3:0] OFS_ACC_I = 4'h7;
   localparam logic [3:0] OFS_ACC_J = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'h9;
   localparam logic [3:0] OFS_COMMAND_PASS_THROUGH_REGISTER = 4'hA;
   localparam logic [3:0] OFS_PPR = 4'hB;
   localparam logic [3:0] OFS_FLAGS = 4'hC;
   // config register fields
   localparam int CFG_EOS = 0;
   localparam int CFG_NL = 1;
   localparam int CFG_PP1 = 2;
   localparam int CFG_STATUS_BYTE_OUT_IRQ_ENABLE = 3;
   localparam int CFG_ULPA = 4;
   localparam int CFG_IST = 5;
   // serial poll mode register service request bit
   localparam int SERIAL_POLL_MODE_REGISTER_RSV = 6;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // settle times in ns and their cycle counts (rounded down, no minimum)
   localparam int CLK_NS = 40;
   localparam int T1_NORM_NS = 2000;
   localparam int T1_SHORT_NS = 1100;
   localparam int T1_VSHORT_NS = 500;
   localparam logic [7:0] T1_NORM_CYC = 8'(T1_NORM_NS / CLK_NS);
   localparam logic [7:0] T1_SHORT_CYC = 8'(T1_SHORT_NS / CLK_NS);
   localparam logic [7:0] T1_VSHORT_CYC = 8'(T1_VSHORT_NS / CLK_NS);
endpackage

// ### rtl/aux_set_clear_bit.sv
// one set/clear flag of the command decoder with a forced clear
// assumes synchronous active-high reset and one-cycle strobes
`timescale 1ns/10ps
module aux_set_clear_bit
   import aux_cmd_pkg::*;
(
   input wire logic core_clk_i, // core clock
   input wire logic sys_rst_i, // synchronous reset
   input wire logic set_i, // set strobe
   input wire logic clr_i, // clear strobe
   input wire logic force_clr_i, // chip reset clear
   output logic q_o // flag value
);
   typedef struct packed
   {
      logic q;
   } st_t;
   st_t s_reg;
   st_t s_next;
   // set wins over a clear in the same cycle
   always_comb
   begin
      s_next = s_reg;
      if (clr_i || force_clr_i)
      begin
         s_next.q = 1'b0;
      end
      if (set_i)
      begin
         s_next.q = 1'b1;
      end
   end
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end
   assign q_o = s_reg.q;
endmodule

// ### rtl/t1_delay_counter.sv
// source handshake settle timer: counts a loaded number of cycles
// assumes start is a one-cycle strobe
`timescale 1ns/10ps
module t1_delay_counter
   import aux_cmd_pkg::*;
(
   input wire logic core_clk_i, // core clock
   input wire logic sys_rst_i, // synchronous reset
   input wire logic start_i, // begin settle time
   input wire logic [7:0] cycles_i, // cycle count to wait
   output logic done_o // settle time elapsed (pulse)
);
   typedef struct packed
   {
      logic [7:0] cnt;
      logic busy;
      logic done;
   } st_t;
   st_t s_reg;
   st_t s_next;
   always_comb
   begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (start_i)
      begin
         s_next.cnt = cycles_i;
         s_next.busy = 1'b1;
      end
      else if (s_reg.busy)
      begin
         if (s_reg.cnt <= 8'h01)
         begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
         end
         else
            s_next.cnt = s_reg.cnt - 8'h01;
      end
   end
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end
   assign done_o = s_reg.done;
endmodule

// ### rtl/gpib_aux_command_decoder.sv
// auxiliary command decoder: command port, poll/service request control,
// settle time selection and chip reset of configuration state.
// assumes the local port master keeps strobes one cycle wide and that
// the bus-side engine reports secondaries, poll byte send and polls.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module gpib_aux_command_decoder
   import aux_cmd_pkg::*;
(
   input wire logic core_clk_i, // core clock
   input wire logic sys_rst_i, // synchronous reset
   input wire logic [3:0] addr_i, // register address
   input wire logic [7:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   output logic [7:0] rdata_o, // read data, cycle after rd_i
   input wire logic irq_raw_i, // combined masked interrupt
   input wire logic sec_rx_i, // secondary byte received
   input wire logic [7:0] sec_byte_i, // received secondary byte
   input wire logic ppc_rx_i, // configure command received
   input wire logic ppe_rx_i, // enable command received
   input wire logic stb_sent_i, // status byte sent in poll
   input wire logic talk_byte_i, // talker sends a data byte
   output logic int_o, // interrupt pin
   output logic swrst_o, // soft reset message
   output logic lon_o, // listener forced active
   output logic ton_o, // talker forced active
   output logic eoi_o, // end-or-identify with this byte
   output logic unc_o, // unrecognized command flag
   output logic rsv_o, // local service request
   output logic legacy_o, // legacy compatibility mode
   output logic [7:0] t1_cycles_o, // settle time in cycles
   output logic t1_done_o, // settle time elapsed pulse
   output logic [7:0] ppr_o // poll response value
);
   typedef struct packed
   {
      logic swrst;
      logic feoi;
      logic pts;
      logic unrecognized_command_flag;
      logic legacy;
      logic rsv;
      logic req_pend;
      logic req_val;
      logic [7:0] serial_poll_mode_register;
      logic [7:0] cfg;
      logic [7:0] acc_a;
      logic [7:0] acc_b;
      logic [7:0] acc_e;
      logic [7:0] acc_f;
      logic [7:0] acc_i;
      logic [7:0] acc_j;
      logic [7:0] command_pass_through_register;
      logic [7:0] poll_response_register;
      logic [7:0] rdata;
      logic [7:0] t1;
      logic eoi;
      logic irq;
   } st_t;
   st_t s_reg;
   st_t s_next;
   logic aux_wr;
   logic [6:0] code;
   logic setf;
   logic chrst;
   logic lon_q;
   logic ton_q;
   logic dai_q;
   logic stdl_q;
   logic vstdl_q;
   logic alt_service_request_q;
   logic alt_service_request_clr;
   // command byte decode, bit 7 is the set form
   assign aux_wr = wr_i && (addr_i == OFS_AUX);
   assign code = wdata_i[6:0];
   assign setf = wdata_i[SET_BIT];
   assign chrst = aux_wr && (code == CMD_CHRST) && !setf;
   // poll byte sent clears the alternate request
   assign alt_service_request_clr = stb_sent_i;
   // paired set/clear flags
   aux_set_clear_bit u_lon
   (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .set_i(aux_wr && code == CMD_LON && setf && !s_reg.swrst),
      .clr_i(aux_wr && code == CMD_LON && !setf),
      .force_clr_i(chrst || s_reg.swrst),
      .q_o(lon_q)
   );
   aux_set_clear_bit u_ton
   (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .set_i(aux_wr && code == CMD_TON && setf && !s_reg.swrst),
      .clr_i(aux_wr && code == CMD_TON && !setf),
      .force_clr_i(chrst || s_reg.swrst),
      .q_o(ton_q)
   );
   aux_set_clear_bit u_dai
   (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .set_i(aux_wr && code == CMD_DAI && setf),
      .clr_i(aux_wr && code == CMD_DAI && !setf),
      .force_clr_i(1'b0),
      .q_o(dai_q)
   );
   aux_set_clear_bit u_stdl
   (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .set_i(aux_wr && code == CMD_STDL && setf),
      .clr_i(aux_wr && code == CMD_STDL && !setf),
      .force_clr_i(1'b0),
      .q_o(stdl_q)
   );
   aux_set_clear_bit u_vstdl
   (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .set_i(aux_wr && code == CMD_VSTDL && setf),
      .clr_i(aux_wr && code == CMD_VSTDL && !setf),
      .force_clr_i(1'b0),
      .q_o(vstdl_q)
   );
   // alternate request; a poll send in the set cycle still loses to set
   aux_set_clear_bit u_alt_service_request
   (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .set_i(aux_wr && code == CMD_ALT_SERVICE_REQUEST && setf),
      .clr_i(aux_wr && code == CMD_ALT_SERVICE_REQUEST && !setf),
      .force_clr_i(alt_service_request_clr),
      .q_o(alt_service_request_q)
   );
   // settle timer started by each talker byte
   t1_delay_counter u_t1
   (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(talk_byte_i),
      .cycles_i(s_reg.t1),
      .done_o(t1_done_o)
   );
   // main next-state logic
   always_comb
   begin
      s_next = s_reg;
      s_next.rdata = RESET_BYTE;
      // settle time select, very short takes priority
      if (vstdl_q)
         s_next.t1 = T1_VSHORT_CYC;
      else if (stdl_q)
         s_next.t1 = T1_SHORT_CYC;
      else
         s_next.t1 = T1_NORM_CYC;
      // end-or-identify rides on next talker byte then drops
      s_next.eoi = 1'b0;
      if (talk_byte_i && s_reg.feoi)
      begin
         s_next.eoi = 1'b1;
         s_next.feoi = 1'b0;
      end
      // status and holdoffs untouched; only the pin is gated
      s_next.irq = irq_raw_i && !dai_q;
      // pass-through and unrecognized command flag
      if (sec_rx_i && s_reg.pts)
      begin
         s_next.unrecognized_command_flag = 1'b1;
         s_next.command_pass_through_register = sec_byte_i;
         s_next.pts = 1'b0;
      end
      if (!s_reg.cfg[CFG_PP1] && (ppc_rx_i || ppe_rx_i))
      begin
         s_next.unrecognized_command_flag = 1'b1;
      end
      if (s_reg.cfg[CFG_PP1] && ppe_rx_i)
      begin
         s_next.poll_response_register = sec_byte_i;
      end
      // reading the flag register clears the unrecognized flag
      if (rd_i && addr_i == OFS_FLAGS)
      begin
         s_next.rdata = {7'h00, s_reg.unrecognized_command_flag};
         if (!(sec_rx_i && s_reg.pts) && !ppc_rx_i && !ppe_rx_i)
            s_next.unrecognized_command_flag = 1'b0;
      end
      // remaining reads
      if (rd_i)
      begin
         case (addr_i)
            OFS_SERIAL_POLL_MODE_REGISTER: s_next.rdata = s_reg.serial_poll_mode_register;
            OFS_CFG: s_next.rdata = s_reg.cfg;
            OFS_ACC_A: s_next.rdata = s_reg.acc_a;
            OFS_ACC_B: s_next.rdata = s_reg.acc_b;
            OFS_ACC_E: s_next.rdata = s_reg.acc_e;
            OFS_ACC_F: s_next.rdata = s_reg.acc_f;
            OFS_ACC_I: s_next.rdata = s_reg.acc_i;
            OFS_ACC_J: s_next.rdata = s_reg.acc_j;
            OFS_STATUS: s_next.rdata = {s_reg.legacy, s_reg.rsv,
               alt_service_request_q, vstdl_q, stdl_q, dai_q, ton_q, lon_q};
            OFS_COMMAND_PASS_THROUGH_REGISTER: s_next.rdata = s_reg.command_pass_through_register;
            OFS_PPR: s_next.rdata = s_reg.poll_response_register;
            OFS_FLAGS: s_next.rdata = {7'h00, s_reg.unrecognized_command_flag};
            default: s_next.rdata = RESET_BYTE;
         endcase
      end
      // register writes
      if (wr_i)
      begin
         case (addr_i)
            OFS_SERIAL_POLL_MODE_REGISTER:
            begin
               s_next.serial_poll_mode_register = wdata_i;
               if (s_reg.req_pend)
               begin
                  s_next.rsv = s_reg.req_val;
                  s_next.req_pend = 1'b0;
               end
            end
            OFS_CFG: s_next.cfg = wdata_i;
            OFS_ACC_A: s_next.acc_a = wdata_i;
            OFS_ACC_B: s_next.acc_b = wdata_i;
            OFS_ACC_E: s_next.acc_e = wdata_i;
            OFS_ACC_F: s_next.acc_f = wdata_i;
            OFS_ACC_I: s_next.acc_i = wdata_i;
            OFS_ACC_J: s_next.acc_j = wdata_i;
            OFS_PPR: s_next.poll_response_register = wdata_i;
            default: s_next.poll_response_register = s_reg.poll_response_register;
         endcase
      end
      // auxiliary command execution
      if (aux_wr)
      begin
         case (code)
            CMD_SWRST: s_next.swrst = setf;
            CMD_FEOI: s_next.feoi = !setf;
            CMD_PTS: s_next.pts = !setf;
            CMD_SW: s_next.legacy = s_reg.legacy || setf;
            CMD_REQ:
            begin
               if (s_reg.cfg[CFG_STATUS_BYTE_OUT_IRQ_ENABLE])
               begin
                  s_next.rsv = setf;
                  s_next.req_pend = 1'b0;
               end
               else
               begin
                  s_next.req_pend = 1'b1;
                  s_next.req_val = setf;
               end
            end
            default: s_next.legacy = s_reg.legacy;
         endcase
      end
      // chip reset of configuration state
      if (chrst)
      begin
         s_next.swrst = 1'b1;
         s_next.feoi = 1'b0;
         s_next.pts = 1'b0;
         s_next.serial_poll_mode_register = RESET_BYTE;
         s_next.cfg[CFG_EOS] = 1'b0;
         s_next.cfg[CFG_NL] = 1'b0;
         s_next.cfg[CFG_IST] = 1'b0;
         s_next.cfg[CFG_ULPA] = 1'b0;
         s_next.acc_a = RESET_BYTE;
         s_next.acc_b = RESET_BYTE;
         s_next.acc_e = RESET_BYTE;
         s_next.acc_f = RESET_BYTE;
         s_next.acc_i = RESET_BYTE;
         s_next.acc_j = RESET_BYTE;
         s_next.req_pend = 1'b0;
      end
   end
   // state register, hardware reset sets soft reset message
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         s_reg <= '0;
         s_reg.swrst <= 1'b1;
         s_reg.t1 <= T1_NORM_CYC;
      end
      else
         s_reg <= s_next;
   end
   // outputs; service request combines all three sources
   logic rsv_q;
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         rsv_q <= 1'b0;
      else
         rsv_q <= (s_next.rsv || s_next.serial_poll_mode_register[SERIAL_POLL_MODE_REGISTER_RSV] || alt_service_request_q)
            && !s_next.swrst;
   end
   assign rdata_o = s_reg.rdata;
   assign int_o = s_reg.irq;
   assign swrst_o = s_reg.swrst;
   assign lon_o = lon_q;
   assign ton_o = ton_q;
   assign eoi_o = s_reg.eoi;
   assign unc_o = s_reg.unrecognized_command_flag;
   assign rsv_o = rsv_q;
   assign legacy_o = s_reg.legacy;
   assign t1_cycles_o = s_reg.t1;
   assign ppr_o = s_reg.poll_response_register;
endmodule

// ### bench/aux_cmd_checker_props.sv
// port checker for the auxiliary command decoder
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/10ps
module aux_cmd_checker
   import aux_cmd_pkg::*;
(
   input wire logic core_clk_i, // core clock
   input wire logic sys_rst_i, // synchronous reset
   input wire logic [3:0] addr_i, // register address
   input wire logic [7:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic irq_raw_i, // masked interrupt
   input wire logic sec_rx_i, // secondary received
   input wire logic talk_byte_i, // talker byte
   input wire logic int_o, // interrupt pin
   input wire logic swrst_o, // soft reset message
   input wire logic lon_o, // listener forced
   input wire logic ton_o, // talker forced
   input wire logic eoi_o, // end-or-identify
   input wire logic unc_o, // unrecognized flag
   input wire logic rsv_o, // service request
   input wire logic legacy_o, // legacy mode
   input wire logic [7:0] t1_cycles_o // settle cycles
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic aux_wr;
   // a command byte is taken on this edge
   assign aux_wr = wr_i && addr_i == OFS_AUX;

   a_lon_set: assert property (
      aux_wr && wdata_i == 8'h89 && !swrst_o |=> lon_o)
      else $error("listener not forced active");
   a_lon_clr: assert property (
      aux_wr && wdata_i == 8'h09 |=> !lon_o)
      else $error("listener still forced");
   a_ton_set: assert property (
      aux_wr && wdata_i == 8'h8A && !swrst_o |=> ton_o)
      else $error("talker not forced active");
   a_ton_clr: assert property (
      aux_wr && wdata_i == 8'h0A |=> !ton_o)
      else $error("talker still forced");
   a_dai_block: assert property (
      aux_wr && wdata_i == 8'h93 |-> ##2 !int_o)
      else $error("interrupt pin not blocked");
   a_int_cause: assert property (
      int_o |-> $past(irq_raw_i))
      else $error("interrupt pin without cause");
   a_t1_vshort: assert property (
      aux_wr && wdata_i == 8'h97 |-> ##[1:2] t1_cycles_o == T1_VSHORT_CYC)
      else $error("very short settle not applied");
   a_eoi_cause: assert property (
      eoi_o |-> $past(talk_byte_i))
      else $error("end-or-identify without a byte");
   a_pts_flag: assert property (
      aux_wr && wdata_i == 8'h14 ##2 sec_rx_i |=> unc_o)
      else $error("secondary not passed through");
   a_chrst_swrst: assert property (
      aux_wr && wdata_i == 8'h1C |=> swrst_o)
      else $error("chip reset left soft reset clear");
   a_swrst_idle: assert property (
      swrst_o && $past(swrst_o) |-> !lon_o && !ton_o && !rsv_o)
      else $error("function active under soft reset");
   a_legacy_hold: assert property (
      (aux_wr && wdata_i == 8'h99) || legacy_o |=> legacy_o)
      else $error("legacy mode not held");
endmodule

bind gpib_aux_command_decoder aux_cmd_checker u_aux_cmd_checker (.*);

// ### bench/aux_bus_model.sv
// far-side model: bus engine events and the masked interrupt level
// assumes calls from mid-cycle; every task returns in mid-cycle
`timescale 1ns/10ps
module aux_bus_model (
   input wire logic core_clk_i, // core clock
   output logic irq_raw_o, // masked interrupt level
   output logic sec_rx_o, // secondary received pulse
   output logic [7:0] sec_byte_o, // secondary value
   output logic ppc_rx_o, // configure received pulse
   output logic ppe_rx_o, // enable received pulse
   output logic stb_sent_o, // status byte sent pulse
   output logic talk_byte_o // talker byte pulse
);
   // byte line carries junk outside a transfer, never the last value
   initial
   begin
      {irq_raw_o, sec_rx_o, ppc_rx_o, ppe_rx_o} = 4'h0;
      {stb_sent_o, talk_byte_o} = 2'h0;
      sec_byte_o = 8'h5A;
   end
   task automatic set_irq(input logic v);
      @(posedge core_clk_i);
      irq_raw_o <= v;
      @(negedge core_clk_i);
   endtask
   // controller sends one secondary byte
   task automatic send_sec(input logic [7:0] b);
      @(posedge core_clk_i);
      sec_byte_o <= b;
      sec_rx_o <= 1'b1;
      @(posedge core_clk_i);
      sec_rx_o <= 1'b0;
      sec_byte_o <= ~b;
      @(negedge core_clk_i);
   endtask
   // one-cycle event: 0 configure, 1 enable, 2 status byte out, 3 talk
   task automatic pulse(input int k);
      @(posedge core_clk_i);
      ppc_rx_o <= k == 0;
      ppe_rx_o <= k == 1;
      stb_sent_o <= k == 2;
      talk_byte_o <= k == 3;
      @(posedge core_clk_i);
      {ppc_rx_o, ppe_rx_o, stb_sent_o, talk_byte_o} <= 4'h0;
      @(negedge core_clk_i);
   endtask
endmodule

// ### bench/gpib_aux_command_decoder_tb.sv
// testbench for the auxiliary command decoder over its local port
// assumes the far-side model drives every bus-side input
`timescale 1ns/10ps
module gpib_aux_command_decoder_tb;
   import aux_cmd_pkg::*;
   logic core_clk_i, sys_rst_i, wr_i, rd_i, int_o, swrst_o, lon_o, ton_o;
   logic eoi_o, unc_o, rsv_o, legacy_o, t1_done_o, irq_raw_i, sec_rx_i;
   logic ppc_rx_i, ppe_rx_i, stb_sent_i, talk_byte_i;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o, sec_byte_i, t1_cycles_o, ppr_o, v;
   logic [6:0] cmds [6] = '{CMD_LON, CMD_TON, CMD_DAI, CMD_STDL,
      CMD_VSTDL, CMD_ALT_SERVICE_REQUEST};
   int num_errors = 0;
   int checks = 0;

   gpib_aux_command_decoder u_gpib_aux_command_decoder (.*);
   aux_bus_model u_aux_bus_model (.core_clk_i(core_clk_i),
      .irq_raw_o(irq_raw_i), .sec_rx_o(sec_rx_i), .sec_byte_o(sec_byte_i),
      .ppc_rx_o(ppc_rx_i), .ppe_rx_o(ppe_rx_i), .stb_sent_o(stb_sent_i),
      .talk_byte_o(talk_byte_i));

   initial
   begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   task automatic test_done;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk_bit(input string what, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic chk_byte(input string what, input logic [7:0] e,
      input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   // one-cycle strobes; both return in mid-cycle with effects settled
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(negedge core_clk_i);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(negedge core_clk_i);
      d = rdata_o;
   endtask

   // hang guard far above the test's run time
   initial
   begin
      #2000000;
      num_errors++;
      test_done;
   end

   initial
   begin
      sys_rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      repeat (10) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      @(negedge core_clk_i);
      chk_bit("soft reset", 1'b1, swrst_o);
      chk_byte("settle", T1_NORM_CYC, t1_cycles_o);
      wr(OFS_AUX, 8'h00);
      chk_bit("soft reset", 1'b0, swrst_o);
      // every paired command, set then clear, seen in the status byte
      for (int i = 0; i < 6; i++)
      begin
         wr(OFS_AUX, {1'b1, cmds[i]});
         rd(OFS_STATUS, v);
         chk_byte("status set", 8'h01 << i, v & 8'hBF);
         wr(OFS_AUX, {1'b0, cmds[i]});
         rd(OFS_STATUS, v);
         chk_byte("status clear", 8'h00, v & 8'hBF);
      end
      // settle select lands one cycle after the flag itself
      wr(OFS_AUX, 8'h95);
      @(negedge core_clk_i);
      chk_byte("settle", T1_SHORT_CYC, t1_cycles_o);
      wr(OFS_AUX, 8'h97);
      @(negedge core_clk_i);
      chk_byte("settle", T1_VSHORT_CYC, t1_cycles_o);
      wr(OFS_AUX, 8'h17);
      @(negedge core_clk_i);
      chk_byte("settle", T1_SHORT_CYC, t1_cycles_o);
      wr(OFS_AUX, 8'h15);
      @(negedge core_clk_i);
      chk_byte("settle", T1_NORM_CYC, t1_cycles_o);
      // pin follows the pending interrupt unless blocked
      u_aux_bus_model.set_irq(1'b1);
      @(negedge core_clk_i);
      chk_bit("irq pin", 1'b1, int_o);
      wr(OFS_AUX, 8'h93);
      @(negedge core_clk_i);
      chk_bit("irq pin", 1'b0, int_o);
      wr(OFS_AUX, 8'h13);
      @(negedge core_clk_i);
      chk_bit("irq pin", 1'b1, int_o);
      u_aux_bus_model.set_irq(1'b0);
      wr(OFS_AUX, 8'h08);
      u_aux_bus_model.pulse(3);
      chk_bit("eoi", 1'b1, eoi_o);
      u_aux_bus_model.pulse(3);
      chk_bit("eoi", 1'b0, eoi_o);
      // settle timer restarted by the last talker byte
      repeat (T1_NORM_CYC - 1) @(negedge core_clk_i);
      chk_bit("settle done", 1'b0, t1_done_o);
      @(negedge core_clk_i);
      chk_bit("settle done", 1'b1, t1_done_o);
      // software remote poll configuration
      wr(OFS_CFG, 8'h00);
      u_aux_bus_model.pulse(0);
      chk_bit("unrec flag", 1'b1, unc_o);
      rd(OFS_FLAGS, v);
      wr(OFS_AUX, 8'h14);
      u_aux_bus_model.send_sec(8'h65);
      chk_bit("unrec flag", 1'b1, unc_o);
      rd(OFS_COMMAND_PASS_THROUGH_REGISTER, v);
      chk_byte("pass byte", 8'h65, v);
      rd(OFS_FLAGS, v);
      wr(OFS_PPR, 8'h0D);
      chk_byte("poll resp", 8'h0D, ppr_o);
      wr(OFS_CFG, 8'h01 << CFG_PP1);
      u_aux_bus_model.pulse(0);
      u_aux_bus_model.pulse(1);
      chk_bit("unrec flag", 1'b0, unc_o);
      // service request: immediate, deferred, alternate bit
      wr(OFS_CFG, 8'h01 << CFG_STATUS_BYTE_OUT_IRQ_ENABLE);
      wr(OFS_AUX, 8'h9A);
      chk_bit("rsv", 1'b1, rsv_o);
      wr(OFS_AUX, 8'h1A);
      chk_bit("rsv", 1'b0, rsv_o);
      wr(OFS_CFG, 8'h00);
      wr(OFS_AUX, 8'h9A);
      chk_bit("rsv", 1'b0, rsv_o);
      wr(OFS_SERIAL_POLL_MODE_REGISTER, 8'h00);
      chk_bit("rsv", 1'b1, rsv_o);
      wr(OFS_AUX, 8'h1A);
      wr(OFS_SERIAL_POLL_MODE_REGISTER, 8'h00);
      chk_bit("rsv", 1'b0, rsv_o);
      wr(OFS_AUX, 8'h98);
      wr(OFS_SERIAL_POLL_MODE_REGISTER, 8'h3F);
      chk_bit("rsv", 1'b1, rsv_o);
      u_aux_bus_model.pulse(2);
      // alternate bit reaches the pin one cycle after it flips
      @(negedge core_clk_i);
      chk_bit("rsv", 1'b0, rsv_o);
      wr(OFS_AUX, 8'h99);
      chk_bit("legacy", 1'b1, legacy_o);
      // chip reset wipes poll mode, accessory and EOS, NL, ULPA, IST config bits
      wr(OFS_SERIAL_POLL_MODE_REGISTER, 8'h40);
      wr(OFS_CFG, 8'h33);
      for (int i = 3; i < 9; i++)
      begin
         wr(4'(i), 8'hFF);
         rd(4'(i), v);
         chk_byte("accessory", 8'hFF, v);
      end
      wr(OFS_AUX, 8'h89);
      wr(OFS_AUX, 8'h1C);
      chk_bit("soft reset", 1'b1, swrst_o);
      chk_bit("listener", 1'b0, lon_o);
      rd(OFS_SERIAL_POLL_MODE_REGISTER, v);
      chk_byte("poll mode", 8'h00, v);
      rd(OFS_CFG, v);
      chk_byte("config", 8'h00, v & 8'h33);
      for (int i = 3; i < 9; i++)
      begin
         rd(4'(i), v);
         chk_byte("accessory", 8'h00, v);
      end
      rd(4'hF, v);
      chk_byte("unmapped", 8'h00, v);
      test_done;
   end
endmodule
